//--- src/icp_link_top.sv
// Single-pin half-duplex programming link: auto-baud, receiver, transmitter, command gate.
// Assumes an external pull-up on the pin and a host that drives it through open drain.
`timescale 1ns/100ps
`include "icp_consts.svh"

module icp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_clk, // System clock.
	input wire logic i_rst, // Synchronous reset, active high.
	input wire logic i_ce, // Clock enable.
	input wire logic i_flush, // Drop all content.
	input wire logic i_wr_valid, // Write request.
	output logic o_wr_ready, // Room for a word.
	input wire logic [WIDTH-1:0] i_wr_data, // Write data.
	output logic o_rd_valid, // A word is waiting.
	input wire logic i_rd_ready, // Reader takes the word.
	output logic [WIDTH-1:0] o_rd_data // Oldest word.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic wr_ready_q;
	logic rd_valid_q;
	wire push = i_wr_valid && wr_ready_q;
	wire pop = i_rd_ready && rd_valid_q;

	// Occupancy next value; ready and valid are registered from it so they stay honest.
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign o_wr_ready = wr_ready_q;
	assign o_rd_valid = rd_valid_q;
	assign o_rd_data = mem_q[rptr_q];

	// Pointers and flags.
	always_ff @(posedge i_clk) begin
		if (i_rst || (i_ce && i_flush)) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			wr_ready_q <= 1'b1;
			rd_valid_q <= 1'b0;
		end else if (i_ce) begin
			wptr_q <= wptr_q + AW'(push);
			rptr_q <= rptr_q + AW'(pop);
			cnt_q <= cnt_d;
			wr_ready_q <= cnt_d != (AW+1)'(DEPTH);
			rd_valid_q <= cnt_d != '0;
		end
	end

	// Storage, one register per word.
	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem_q[wptr_q] <= i_wr_data;
		end
	end
endmodule

module icp_link_top (
	input wire logic i_mclk, // System clock, 20 MHz.
	input wire logic i_rst, // Synchronous reset, active high.
	input wire logic i_ce, // Clock enable; low freezes everything.
	input wire logic i_prog_pin, // Level seen on the programming pin.
	output logic o_prog_pin_out, // Output value of the pin, always low.
	output logic o_prog_pin_oe, // High while the link pulls the pin low.
	input wire logic i_flash_access_enable, // Flash access enable bit of the control register.
	input wire logic i_flash_rw_protect_bit, // Whole-array read/write protect option.
	input wire logic i_lower_half_protect_bit, // Lower-half protect option.
	input wire logic i_cmd_done, // Pulse: command finished, next byte is a command.
	output logic o_cmd_valid, // Pulse: an accepted command byte.
	output logic [7:0] o_cmd_byte, // Accepted command byte.
	output logic o_cmd_protect, // Flash access of this command is protection-limited.
	output logic o_data_valid, // Pulse: a non-command received byte.
	output logic [7:0] o_data, // Received data byte.
	output logic o_abort, // Pulse: serial error, command aborted.
	output logic o_link_active, // Bit period learned.
	output logic [9:0] o_bit_cycles, // Learned bit period in cycles.
	input wire logic i_tx_valid, // Response byte offered.
	output logic o_tx_ready, // Response byte taken.
	input wire logic [7:0] i_tx_data // Response byte.
);
	icp_pkg::icp_state_e state_q, state_d;
	logic s1_q, s2_q, s3_q, rx_q;
	logic [10:0] cnt_q, cnt_d;
	logic [3:0] bitn_q, bitn_d;
	logic [7:0] sh_q, sh_d;
	logic [13:0] low_q, low_d;
	logic [15:0] ecnt_q, ecnt_d;
	logic [10:0] gcnt_q, gcnt_d;
	logic [9:0] bit_q, bit_d;
	logic oe_q, oe_d;
	logic act_q;
	logic rx_done, err_enter, fifo_pop;
	logic expect_q, resp_en_q;
	logic cmd_v_q, data_v_q, abort_q, prot_q;
	logic [7:0] cmd_q, data_q;
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Timing derived from the learned bit period.
	wire [9:0] meas_bits = 10'(low_q >> `ICP_AB_SHIFT);
	wire [9:0] half_w = (bit_q[9:1] == 9'h000) ? 10'h001 : {1'b0, bit_q[9:1]};
	wire [10:0] stop_w = {1'b0, bit_q} + {1'b0, half_w};
	wire bit_end = cnt_q == ({1'b0, bit_q} - 11'h001);
	wire half_end = cnt_q == ({1'b0, half_w} - 11'h001);
	wire stop_end = cnt_q == (stop_w - 11'h001);
	wire [13:0] brk_lim = 14'({4'h0, bit_q} * `ICP_BRK_BITS);
	wire [15:0] err_lim = 16'({6'h00, bit_q} * `ICP_ERR_BITS);
	wire rx_phase = (state_q == icp_pkg::ST_HUNT) || (state_q == icp_pkg::ST_RX_START)
		|| (state_q == icp_pkg::ST_RX_DATA) || (state_q == icp_pkg::ST_RX_STOP);
	wire brk_hit = rx_phase && !rx_q && (low_q >= brk_lim);
	// Transmit only idle, guarded, in answer to a command, with nothing arriving.
	wire tx_go = rx_q && gcnt_q == 11'h000 && resp_en_q && fifo_valid;

	// Command gate: the always-open subset and the flash-access-only set.
	function automatic logic cmd_ok(input logic [7:0] c, input logic fa);
		case (c)
			`ICP_CMD_REV, `ICP_CMD_STAT, `ICP_CMD_WCTL: cmd_ok = 1'b1;
			`ICP_CMD_RCTL, `ICP_CMD_RBAUD: cmd_ok = 1'b1;
			`ICP_CMD_WTEST, `ICP_CMD_RTEST: cmd_ok = 1'b1;
			`ICP_CMD_WFCR, `ICP_CMD_RFCR, `ICP_CMD_CRC: cmd_ok = fa;
			`ICP_CMD_WFLASH, `ICP_CMD_RFLASH: cmd_ok = fa;
			default: cmd_ok = 1'b0;
		endcase
	endfunction

	wire cmd_accept = rx_done && expect_q && cmd_ok(sh_d, i_flash_access_enable);
	wire is_flash_cmd = (sh_d == `ICP_CMD_WFLASH) || (sh_d == `ICP_CMD_RFLASH);

	// Link sequencer. The rising edge of the pin is seen four cycles late, so the
	// low time measured for 80H and the mid-bit samples share the same lag.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 11'h001;
		bitn_d = bitn_q;
		sh_d = sh_q;
		low_d = rx_q ? 14'h0000 : ((low_q == `ICP_AB_MAX) ? low_q : low_q + 14'h0001);
		ecnt_d = 16'h0000;
		gcnt_d = (gcnt_q == 11'h000) ? gcnt_q : gcnt_q - 11'h001;
		bit_d = bit_q;
		oe_d = 1'b0;
		rx_done = 1'b0;
		fifo_pop = 1'b0;
		case (state_q)
			icp_pkg::ST_AB_IDLE: begin
				bit_d = `ICP_BIT_RST;
				low_d = 14'h0000;
				if (!rx_q) begin
					state_d = icp_pkg::ST_AB_MEAS;
					low_d = 14'h0001;
				end
			end
			icp_pkg::ST_AB_MEAS: begin
				if (rx_q) begin
					bit_d = (meas_bits == 10'h000) ? 10'h001 : meas_bits;
					gcnt_d = 11'(low_q >> 2);
					state_d = icp_pkg::ST_HUNT;
				end else if (low_q == `ICP_AB_MAX) begin
					state_d = icp_pkg::ST_WAIT_HI;
				end
			end
			icp_pkg::ST_HUNT: begin
				cnt_d = 11'h000;
				bitn_d = 4'h0;
				if (!rx_q) begin
					state_d = icp_pkg::ST_RX_START;
				end else if (tx_go) begin
					state_d = icp_pkg::ST_TX_BIT;
					sh_d = fifo_data;
					fifo_pop = 1'b1;
					oe_d = 1'b1;
				end
			end
			icp_pkg::ST_RX_START: begin
				if (half_end) begin
					cnt_d = 11'h000;
					state_d = rx_q ? icp_pkg::ST_HUNT : icp_pkg::ST_RX_DATA;
				end
			end
			icp_pkg::ST_RX_DATA: begin
				if (bit_end) begin
					cnt_d = 11'h000;
					sh_d = {rx_q, sh_q[7:1]};
					bitn_d = bitn_q + 4'h1;
					if (bitn_q == `ICP_LAST_DATA - 4'h1) begin
						state_d = icp_pkg::ST_RX_STOP;
					end
				end
			end
			icp_pkg::ST_RX_STOP: begin
				if (bit_end) begin
					if (rx_q) begin
						rx_done = 1'b1;
						gcnt_d = {1'b0, bit_q};
						state_d = icp_pkg::ST_HUNT;
					end else begin
						state_d = icp_pkg::ST_ERR_BRK;
					end
				end
			end
			icp_pkg::ST_TX_BIT: begin
				oe_d = oe_q;
				if (half_end && !oe_q && !rx_q) begin
					state_d = icp_pkg::ST_ERR_BRK;
				end else if (bitn_q == `ICP_LAST_DATA + 4'h1) begin
					oe_d = 1'b0;
					if (stop_end) begin
						gcnt_d = {1'b0, half_w};
						state_d = icp_pkg::ST_HUNT;
					end
				end else if (bit_end) begin
					cnt_d = 11'h000;
					bitn_d = bitn_q + 4'h1;
					if (bitn_q != 4'h0) begin
						sh_d = {1'b0, sh_q[7:1]};
					end
					if (bitn_q == `ICP_LAST_DATA) begin
						oe_d = 1'b0;
					end else begin
						oe_d = (bitn_q == 4'h0) ? !sh_q[0] : !sh_q[1];
					end
				end
			end
			icp_pkg::ST_ERR_BRK: begin
				oe_d = 1'b1;
				ecnt_d = ecnt_q + 16'h0001;
				if (ecnt_q >= err_lim) begin
					oe_d = 1'b0;
					state_d = icp_pkg::ST_WAIT_HI;
				end
			end
			icp_pkg::ST_WAIT_HI: begin
				bit_d = `ICP_BIT_RST;
				if (rx_q) begin
					state_d = icp_pkg::ST_AB_IDLE;
				end
			end
			default: begin
				state_d = icp_pkg::ST_AB_IDLE;
			end
		endcase
		if (brk_hit) begin
			state_d = icp_pkg::ST_ERR_BRK;
			oe_d = 1'b1;
		end
	end

	assign err_enter = (state_d == icp_pkg::ST_ERR_BRK) && (state_q != icp_pkg::ST_ERR_BRK);

	// Pin synchroniser: a change counts once the second and third stages agree.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			rx_q <= 1'b1;
		end else if (i_ce) begin
			s1_q <= i_prog_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				rx_q <= s3_q;
			end
		end
	end

	// Sequencer registers.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= icp_pkg::ST_AB_IDLE;
			cnt_q <= 11'h000;
			bitn_q <= 4'h0;
			sh_q <= 8'h00;
			low_q <= 14'h0000;
			ecnt_q <= 16'h0000;
			gcnt_q <= 11'h000;
			bit_q <= `ICP_BIT_RST;
			oe_q <= 1'b0;
			act_q <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			bitn_q <= bitn_d;
			sh_q <= sh_d;
			low_q <= low_d;
			ecnt_q <= ecnt_d;
			gcnt_q <= gcnt_d;
			bit_q <= bit_d;
			oe_q <= oe_d;
			act_q <= bit_d != `ICP_BIT_RST;
		end
	end

	// Command front end. An abort wins over a command acceptance in the same cycle.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			expect_q <= 1'b1;
			resp_en_q <= 1'b0;
			cmd_v_q <= 1'b0;
			data_v_q <= 1'b0;
			abort_q <= 1'b0;
			cmd_q <= 8'h00;
			data_q <= 8'h00;
			prot_q <= 1'b0;
		end else if (i_ce) begin
			cmd_v_q <= cmd_accept && !err_enter;
			data_v_q <= rx_done && !expect_q;
			abort_q <= err_enter;
			if (cmd_accept) begin
				cmd_q <= sh_d;
				prot_q <= is_flash_cmd && (i_flash_rw_protect_bit || i_lower_half_protect_bit);
			end
			if (rx_done && !expect_q) begin
				data_q <= sh_d;
			end
			if (err_enter) begin
				expect_q <= 1'b1;
				resp_en_q <= 1'b0;
			end else if (cmd_accept) begin
				expect_q <= 1'b0;
				resp_en_q <= 1'b1;
			end else if (i_cmd_done) begin
				expect_q <= 1'b1;
			end
		end
	end

	// Response buffer; a full buffer stalls the responder through its ready.
	icp_fifo #(.WIDTH(8), .DEPTH(4)) u_tx_fifo (
		.i_clk(i_mclk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_flush(err_enter),
		.i_wr_valid(i_tx_valid),
		.o_wr_ready(o_tx_ready),
		.i_wr_data(i_tx_data),
		.o_rd_valid(fifo_valid),
		.i_rd_ready(fifo_pop),
		.o_rd_data(fifo_data)
	);

	// Outputs, all registered; the pin data is a constant low for open drain.
	assign o_prog_pin_out = 1'b0;
	assign o_prog_pin_oe = oe_q;
	assign o_cmd_valid = cmd_v_q;
	assign o_cmd_byte = cmd_q;
	assign o_cmd_protect = prot_q;
	assign o_data_valid = data_v_q;
	assign o_data = data_q;
	assign o_abort = abort_q;
	assign o_link_active = act_q;
	assign o_bit_cycles = bit_q;
endmodule

//--- shared/icp_consts.svh
// Timing counts, command codes and reset values of the single-pin programming link.
// Assumes a bit period learned in system clock cycles; all counts except the calibration give-up limit scale from it.
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH

// Low bits of the 80H calibration character: start plus seven zero bits, log2 of eight.
`define ICP_AB_SHIFT 3
// Low time at which calibration gives up, in cycles.
`define ICP_AB_MAX 14'h1FFF
// Serial break threshold, in bit periods.
`define ICP_BRK_BITS 14'h0009
// Length of the break sent back on an error: four characters of 10.5 bits.
`define ICP_ERR_BITS 16'h002A
// Number of data bits in a character.
`define ICP_LAST_DATA 4'h8
// Command codes.
`define ICP_CMD_REV 8'h00
`define ICP_CMD_STAT 8'h02
`define ICP_CMD_WCTL 8'h04
`define ICP_CMD_RCTL 8'h05
`define ICP_CMD_WFCR 8'h08
`define ICP_CMD_RFCR 8'h09
`define ICP_CMD_WFLASH 8'h0A
`define ICP_CMD_RFLASH 8'h0B
`define ICP_CMD_CRC 8'h0E
`define ICP_CMD_RBAUD 8'h1B
`define ICP_CMD_WTEST 8'hF0
`define ICP_CMD_RTEST 8'hF1
// Reset value of the learned bit period: zero means not yet calibrated.
`define ICP_BIT_RST 10'h000

`endif

//--- shared/icp_pkg.sv
// Types of the single-pin programming link.
// Assumes the constants header is included by the design files that need timing.
package icp_pkg;

	// Link states, Gray coded along calibrate, hunt, receive and transmit.
	typedef enum logic [3:0] {
		ST_AB_IDLE = 4'h0,
		ST_AB_MEAS = 4'h1,
		ST_HUNT = 4'h3,
		ST_RX_START = 4'h2,
		ST_RX_DATA = 4'h6,
		ST_RX_STOP = 4'h7,
		ST_TX_BIT = 4'h5,
		ST_ERR_BRK = 4'h4,
		ST_WAIT_HI = 4'hC
	} icp_state_e;

endpackage

//--- tb/icp_link_assertions.sv
// Port-level checker for the single-pin programming link top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module icp_link_chk (
	input wire logic i_mclk, // System clock.
	input wire logic i_rst, // Synchronous reset.
	input wire logic i_flash_access_enable, // Flash access mode.
	input wire logic i_flash_rw_protect_bit, // Whole-array protect.
	input wire logic i_lower_half_protect_bit, // Lower-half protect.
	input wire logic o_prog_pin_out, // Pin data.
	input wire logic o_prog_pin_oe, // Pin pull-down.
	input wire logic o_cmd_valid, // Command pulse.
	input wire logic [7:0] o_cmd_byte, // Command byte.
	input wire logic o_cmd_protect, // Protection flag.
	input wire logic o_data_valid, // Data pulse.
	input wire logic o_abort, // Error pulse.
	input wire logic o_link_active, // Rate learned.
	input wire logic [9:0] o_bit_cycles // Learned bit period.
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Every byte needs a whole frame, so two results never come within eight cycles.
	property p_od_low; o_prog_pin_out == 1'b0; endproperty
	property p_frame_gap; o_cmd_valid |=> !(o_cmd_valid || o_data_valid) [*8]; endproperty
	property p_err_break; o_abort |-> ##[0:2] o_prog_pin_oe ##1 o_prog_pin_oe [*8]; endproperty
	property p_err_rebaud; o_abort |-> ##[1:1000] !o_link_active; endproperty
	property p_half_duplex; (o_cmd_valid || o_data_valid) |-> !o_prog_pin_oe; endproperty
	property p_active; o_link_active == (o_bit_cycles != 10'h000); endproperty
	property p_quiet; !o_link_active |-> !(o_cmd_valid || o_data_valid); endproperty
	property p_cmd_set; o_cmd_valid |-> (o_cmd_byte inside {8'h00, 8'h02, 8'h04, 8'h05,
		8'h1B, 8'hF0, 8'hF1} || (i_flash_access_enable && o_cmd_byte inside {8'h08,
		8'h09, 8'h0A, 8'h0B, 8'h0E})); endproperty
	property p_protect; o_cmd_valid |-> o_cmd_protect == (o_cmd_byte inside {8'h0A, 8'h0B}
		&& (i_flash_rw_protect_bit || i_lower_half_protect_bit)); endproperty
	a_od_low: assert property (p_od_low) else $error("pin data not low");
	a_frame_gap: assert property (p_frame_gap) else $error("results too close");
	a_err_break: assert property (p_err_break) else $error("no break after error");
	a_err_rebaud: assert property (p_err_rebaud) else $error("rate kept after error");
	a_half_duplex: assert property (p_half_duplex) else $error("drive while receiving");
	a_active: assert property (p_active) else $error("active flag wrong");
	a_quiet: assert property (p_quiet) else $error("byte before calibration");
	a_cmd_set: assert property (p_cmd_set) else $error("command not allowed");
	a_protect: assert property (p_protect) else $error("protect flag wrong");
	c_cmd: cover property (o_cmd_valid);
	c_data: cover property (o_data_valid);
	c_abort: cover property (o_abort);
endmodule
bind icp_link_top icp_link_chk icp_link_chk_i (.*);

//--- tb/icp_host_model.sv
// Host serial port behind an open-drain buffer, with pull-up on the shared pin.
// Assumes the bench sets the bit period and calls the tasks just after a clock edge.
`timescale 1ns/100ps
module icp_host_model (
	input wire logic i_clk, // System clock, used as time base.
	input wire logic i_dev_oe, // Device pulls the pin low.
	output logic o_line // Resolved pin level.
);
	logic drv_low = 1'b0;
	int bitc = 16; // Clock over 16 stays below the asynchronous limit.
	bit listen = 1'b0;
	logic [7:0] rx_q[$];
	// Either party pulling wins; released, the pull-up gives high.
	assign o_line = !(drv_low || i_dev_oe);
	task automatic hold(input logic lvl, input int n);
		drv_low = !lvl;
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// One frame: start, eight bits LSB first, 1.5 stop bits, then a bit idle.
	task automatic send_byte(input logic [7:0] b, input logic stop_hi);
		@(posedge i_clk);
		#1;
		hold(1'b0, bitc);
		for (int i = 0; i < 8; i++) hold(b[i], bitc);
		hold(stop_hi, bitc * 3 / 2);
		if (!stop_hi) hold(1'b0, bitc);
		hold(1'b1, bitc);
	endtask
	// Break on connect or recovery, even over a device transmission.
	task automatic brk(input int nbits);
		@(posedge i_clk);
		#1;
		hold(1'b0, nbits * bitc);
		hold(1'b1, bitc);
	endtask
	// Receiver samples mid-bit; only used while responses are expected.
	always @(posedge i_dev_oe) begin
		logic [7:0] b;
		if (listen) begin
			repeat (bitc / 2) @(posedge i_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bitc) @(posedge i_clk);
				#2 b[i] = o_line;
			end
			rx_q.push_back(b);
		end
	end
endmodule

//--- tb/icp_single_pin_serial_link_bench.sv
// Self-checking bench for the programming link: calibration, commands, replies, errors.
// Assumes the host model file and the checker file are compiled before it.
`timescale 1ns/100ps
module icp_single_pin_serial_link_bench;
	logic clk = 1'b0, rst = 1'b1, en = 1'b0, p_rw = 1'b0, p_lo = 1'b0;
	logic cmd_done = 1'b0, tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic pin, oe, pout, cmd_v, prot, dat_v, abort, act, tx_rdy;
	logic [7:0] cmd_b, dat;
	logic [9:0] bitc;
	int n_mismatch = 0, total_checks = 0, n_abort = 0, k;
	logic [9:0] exp_q[$];
	logic [7:0] txq[$];
	logic [7:0] cmds[19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09,
		8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h1B, 8'h20, 8'hF0, 8'hF1, 8'hF2};
	logic [7:0] c, d;
	always #25 clk = ~clk;
	icp_link_top icp_link_top_i (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_prog_pin(pin),
		.o_prog_pin_out(pout), .o_prog_pin_oe(oe), .i_flash_access_enable(en),
		.i_flash_rw_protect_bit(p_rw), .i_lower_half_protect_bit(p_lo), .i_cmd_done(cmd_done),
		.o_cmd_valid(cmd_v), .o_cmd_byte(cmd_b), .o_cmd_protect(prot), .o_data_valid(dat_v),
		.o_data(dat), .o_abort(abort), .o_link_active(act), .o_bit_cycles(bitc),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_rdy), .i_tx_data(tx_data));
	icp_host_model icp_host_model_i (.i_clk(clk), .i_dev_oe(oe), .o_line(pin));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function automatic logic ok_cmd(input logic [7:0] b);
		return b inside {8'h00, 8'h02, 8'h04, 8'h05, 8'h1B, 8'hF0, 8'hF1} ||
			(en && b inside {8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0E});
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_idle();
		for (k = 0; k < 3000 && act !== 1'b0; k++) cyc(1);
		// The link waits for the released pin to be seen high before it calibrates again.
		cyc(20);
	endtask
	task automatic pulse_done();
		cyc(1);
		cmd_done = 1'b1;
		cyc(1);
		cmd_done = 1'b0;
	endtask
	// Response push holds valid and data until ready is sampled high.
	// Ready is read settled before the edge at which the word is taken; valid stays up
	// between calls and the caller lowers it.
	task automatic push(input logic [7:0] v);
		logic r;
		r = 1'b0;
		tx_valid = 1'b1;
		tx_data = v;
		for (k = 0; k < 50 && !r; k++) begin
			r = tx_rdy === 1'b1;
			@(posedge clk);
		end
		#1;
		if (!r) n_mismatch++;
		txq.push_back(v);
	endtask
	// Every received byte is compared with the oldest expected note, mid-cycle.
	always @(negedge clk) begin
		if ((cmd_v === 1'b1 || dat_v === 1'b1) && exp_q.size() == 0)
			check(10'h3FF, 10'h000);
		else if (cmd_v === 1'b1 || dat_v === 1'b1)
			check({dat_v, prot & !dat_v, dat_v ? dat : cmd_b}, exp_q.pop_front());
		if (abort === 1'b1) n_abort++;
	end
	// The watchdog bound covers the longest run with ample margin.
	initial begin
		void'($urandom(32'h5b7f));
		fork
			begin
				repeat (100000) @(posedge clk);
				n_mismatch++;
				give_verdict();
			end
		join_none
		cyc(6);
		rst = 1'b0;
		check(oe, 1'b0);
		check(act, 1'b0);
		check(tx_rdy, 1'b1);
		for (int i = 0; i < 4; i++) push(8'($urandom));
		tx_valid = 1'b0;
		cyc(200);
		check(tx_rdy, 1'b0);
		check(oe, 1'b0);
		icp_host_model_i.send_byte(8'h80, 1'b1);
		check(bitc, 10'd16);
		icp_host_model_i.listen = 1'b1;
		exp_q.push_back(10'h000);
		icp_host_model_i.send_byte(8'h00, 1'b1);
		for (k = 0; k < 8000 && icp_host_model_i.rx_q.size() < 4; k++) cyc(1);
		for (int i = 0; i < 4; i++)
			check(icp_host_model_i.rx_q.pop_front(), txq.pop_front());
		cyc(100);
		check(tx_rdy, 1'b1);
		icp_host_model_i.listen = 1'b0;
		pulse_done();
		for (int m = 0; m < 2; m++) begin
			en = m[0];
			foreach (cmds[j]) begin
				c = cmds[j];
				d = 8'($urandom);
				{p_rw, p_lo} = 2'($urandom);
				if (ok_cmd(c)) begin
					exp_q.push_back({1'b0, c inside {8'h0A, 8'h0B} && (p_rw || p_lo), c});
					exp_q.push_back({2'b10, d});
				end
				icp_host_model_i.send_byte(c, 1'b1);
				if (ok_cmd(c)) icp_host_model_i.send_byte(d, 1'b1);
				pulse_done();
			end
		end
		check(10'(exp_q.size()), 10'h000);
		icp_host_model_i.send_byte(8'h55, 1'b0);
		wait_idle();
		check(10'(n_abort), 10'd1);
		check(act, 1'b0);
		icp_host_model_i.bitc = 12;
		icp_host_model_i.send_byte(8'h80, 1'b1);
		check(bitc, 10'd12);
		exp_q.push_back(10'h002);
		icp_host_model_i.send_byte(8'h02, 1'b1);
		icp_host_model_i.brk(12);
		wait_idle();
		check(10'(n_abort), 10'd2);
		check(10'(exp_q.size()), 10'h000);
		give_verdict();
	end
endmodule
